/* File: core/key_binner.sv */
/*
  threshold binning of a converter code into a one-hot key index.
  assumes thresholds ascend from key one to key four.
*/
`timescale 1ns/1ps
module key_binner (
  // code and thresholds
  input  wire logic [7:0] code_in,
  input  wire logic [7:0] thr1_in,
  input  wire logic [7:0] thr2_in,
  input  wire logic [7:0] thr3_in,
  // result
  output logic      [3:0] key_onehot_out
);
  always_comb begin
    if (code_in <= thr1_in) begin
      key_onehot_out = 4'h1;
    end else if (code_in <= thr2_in) begin
      key_onehot_out = 4'h2;
    end else if (code_in <= thr3_in) begin
      key_onehot_out = 4'h4;
    end else begin
      key_onehot_out = 4'h8;
    end
  end
endmodule : key_binner

/* File: core/key_raw_pkg.sv */
/*
  constants for the raw converter key press reporting block.
  assumes a 125 MHz clock and a converter front end outside this block.
*/
// Overview of operation
// - enabling raw mode leaves pending press and release flags as they are
// - raw mode ignores key thresholds and does no per-key binning
// - raw mode reports any key on key one press and release flags only
// - clearing detection enable clears raw mode; clearing raw mode clears output
// - accessory removal clears the output; reading it does not
// - manual trigger reconverts in raw mode, pressed or not, without setting key one press
// - output refreshed on key detection completion and on manual trigger
// - every completed conversion in raw mode sets the conversion done flag
// - a completed conversion never reports zero; minimum is one
// - press valid after debounce; sets press, clears release, interrupts
// - release valid after release debounce; sets release flag, interrupts
// - clearing detection enable halts detection and clears all key flags
package key_raw_pkg;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned PRESS_DEB_US     = 20;
  localparam int unsigned RELEASE_DEB_US   = 20;
  localparam int unsigned PRESS_DEB_CYC    = PRESS_DEB_US * CLK_MHZ;
  localparam int unsigned RELEASE_DEB_CYC  = RELEASE_DEB_US * CLK_MHZ;
  localparam int unsigned NUM_KEYS         = 4;
  localparam int unsigned ADC_W            = 8;
  localparam int unsigned CNT_W            = 16;
  localparam logic [7:0]  ADC_CLEAR        = 8'h00;
  localparam logic [7:0]  ADC_MIN          = 8'h01;
  localparam logic [3:0]  FLAGS_CLEAR      = 4'h0;
  localparam logic [3:0]  KEY1_MASK        = 4'h1;
  localparam logic [15:0] CNT_ZERO         = 16'h0000;
  localparam logic [15:0] CNT_ONE          = 16'h0001;
  typedef enum logic [1:0] {ST_IDLE, ST_PRESS_DEB, ST_HELD, ST_REL_DEB} det_state_t;
endpackage : key_raw_pkg

/* File: core/key_raw_report.sv */
/*
  key press detector with raw converter reporting mode.
  assumes a synchronous key_low level from the comparator, and a converter
  that answers a start pulse with a done pulse and code some cycles later.
*/
`timescale 1ns/1ps
module key_raw_report #(
  parameter int unsigned PRESS_DEB   = key_raw_pkg::PRESS_DEB_CYC,
  parameter int unsigned RELEASE_DEB = key_raw_pkg::RELEASE_DEB_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // host control levels and pulses
  input  wire logic       key_detection_enable_in,
  input  wire logic       raw_mode_en_in,
  input  wire logic       manual_trigger_in,
  input  wire logic       removal_in,
  input  wire logic       flags_clear_in,
  input  wire logic [7:0] thr1_in,
  input  wire logic [7:0] thr2_in,
  input  wire logic [7:0] thr3_in,
  // analog front end
  input  wire logic       key_low_in,
  output logic            adc_start_out,
  input  wire logic       adc_done_in,
  input  wire logic [7:0] adc_code_in,
  // status
  output logic            raw_mode_out,
  output logic [7:0]      adc_output_out,
  output logic [3:0]      press_flags_out,
  output logic [3:0]      release_flags_out,
  output logic            conv_done_out,
  output logic            int_n_out
);
  typedef struct packed {
    key_raw_pkg::det_state_t st;
    logic [15:0]             cnt;
    logic                    raw;
    logic [7:0]              adc;
    logic [3:0]              press;
    logic [3:0]              rel;
    logic [3:0]              held_key;
    logic                    conv_done;
    logic                    start;
    logic                    busy;
    logic                    from_press;
  } state_t;

  state_t     cur;
  state_t     next_cur;
  logic [3:0] binned;

  key_binner u_binner (
    .code_in        (adc_code_in),
    .thr1_in        (thr1_in),
    .thr2_in        (thr2_in),
    .thr3_in        (thr3_in),
    .key_onehot_out (binned)
  );

  function automatic logic [7:0] nonzero(input logic [7:0] c);
    nonzero = (c == key_raw_pkg::ADC_CLEAR) ? key_raw_pkg::ADC_MIN : c;
  endfunction : nonzero

  always_comb begin
    next_cur       = cur;
    next_cur.start = 1'b0;
    // host clear of flags first so hardware sets below win
    if (flags_clear_in) begin
      next_cur.press     = key_raw_pkg::FLAGS_CLEAR;
      next_cur.rel       = key_raw_pkg::FLAGS_CLEAR;
      next_cur.conv_done = 1'b0;
    end
    // raw mode follows the host bit while detection is enabled; enabling it touches no flags
    next_cur.raw = raw_mode_en_in & key_detection_enable_in;
    if (!next_cur.raw) begin
      next_cur.adc = key_raw_pkg::ADC_CLEAR;
    end
    if (removal_in) begin
      next_cur.adc = key_raw_pkg::ADC_CLEAR;
    end
    if (!key_detection_enable_in) begin
      next_cur.st    = key_raw_pkg::ST_IDLE;
      next_cur.cnt   = key_raw_pkg::CNT_ZERO;
      next_cur.press = key_raw_pkg::FLAGS_CLEAR;
      next_cur.rel   = key_raw_pkg::FLAGS_CLEAR;
      next_cur.busy  = 1'b0;
    end else begin
      case (cur.st)
        key_raw_pkg::ST_IDLE: begin
          next_cur.cnt = key_raw_pkg::CNT_ZERO;
          if (key_low_in) begin
            next_cur.st = key_raw_pkg::ST_PRESS_DEB;
          end
        end
        key_raw_pkg::ST_PRESS_DEB: begin
          // any glitch restarts the debounce
          if (!key_low_in) begin
            next_cur.st = key_raw_pkg::ST_IDLE;
          end else if (cur.cnt >= 16'(PRESS_DEB)) begin
            next_cur.st         = key_raw_pkg::ST_HELD;
            next_cur.start      = 1'b1;
            next_cur.busy       = 1'b1;
            next_cur.from_press = 1'b1;
            next_cur.cnt        = key_raw_pkg::CNT_ZERO;
          end else begin
            next_cur.cnt = cur.cnt + key_raw_pkg::CNT_ONE;
          end
        end
        key_raw_pkg::ST_HELD: begin
          next_cur.cnt = key_raw_pkg::CNT_ZERO;
          if (!key_low_in && !cur.busy) begin
            next_cur.st = key_raw_pkg::ST_REL_DEB;
          end
        end
        default: begin
          if (key_low_in) begin
            next_cur.st = key_raw_pkg::ST_HELD;
          end else if (cur.cnt >= 16'(RELEASE_DEB)) begin
            next_cur.st  = key_raw_pkg::ST_IDLE;
            next_cur.rel = next_cur.rel | cur.held_key;
          end else begin
            next_cur.cnt = cur.cnt + key_raw_pkg::CNT_ONE;
          end
        end
      endcase
      // manual reconversion only in raw mode, never sets a press flag
      if (manual_trigger_in && cur.raw && !cur.busy && !next_cur.start) begin
        next_cur.start      = 1'b1;
        next_cur.busy       = 1'b1;
        next_cur.from_press = 1'b0;
      end
      if (adc_done_in && cur.busy) begin
        next_cur.busy = 1'b0;
        if (cur.raw) begin
          next_cur.adc       = nonzero(adc_code_in);
          next_cur.conv_done = 1'b1;
          if (cur.from_press) begin
            next_cur.held_key = key_raw_pkg::KEY1_MASK;
          end
        end else if (cur.from_press) begin
          next_cur.held_key = binned;
        end
        if (cur.from_press) begin
          next_cur.press = next_cur.press | next_cur.held_key;
          next_cur.rel   = next_cur.rel & ~next_cur.held_key;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign adc_start_out     = cur.start;
  assign raw_mode_out      = cur.raw;
  assign adc_output_out    = cur.adc;
  assign press_flags_out   = cur.press;
  assign release_flags_out = cur.rel;
  assign conv_done_out     = cur.conv_done;
  // level interrupt: releases only when every flag is cleared
  assign int_n_out = ~(|cur.press | |cur.rel | cur.conv_done);
endmodule : key_raw_report

/* File: dv/adc_model.sv */
/* converter model: answers a start pulse with done and code.
   assumes the bench sets latency and code before the start. */
`timescale 1ns/1ps
module adc_model (
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [3:0] lat_in,
  input  wire logic [7:0] val_in,
  output logic            done_out,
  output logic [7:0]      code_out
);
  initial begin
    done_out = 1'b0;
    code_out = 8'h5a;
    forever begin
      @(posedge clk_in);
      if (start_in) begin
        repeat (lat_in) @(posedge clk_in);
        done_out <= 1'b1;
        code_out <= val_in;
        @(posedge clk_in);
        done_out <= 1'b0;
        // code is only valid with done, so show garbage afterwards
        code_out <= ~val_in;
      end
    end
  end
endmodule : adc_model

/* File: dv/key_raw_report_properties.sv */
/* port checker for key_raw_report.
   assumes it is bound to the block and sees its ports only. */
`timescale 1ns/1ps
module key_raw_report_properties (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic       key_detection_enable_in,
  input wire logic       removal_in,
  input wire logic       key_low_in,
  input wire logic       adc_done_in,
  input wire logic       adc_start_out,
  input wire logic       raw_mode_out,
  input wire logic [7:0] adc_output_out,
  input wire logic [3:0] press_flags_out,
  input wire logic [3:0] release_flags_out,
  input wire logic       conv_done_out,
  input wire logic       int_n_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_enable_drops_raw: assert property (!key_detection_enable_in |=> !raw_mode_out)
    else $error("raw mode kept");
  a_raw_off_clears: assert property (!raw_mode_out [*2] |-> adc_output_out == 8'h00)
    else $error("output kept");
  a_removal_clears: assert property (removal_in |=> adc_output_out == 8'h00)
    else $error("output kept");
  a_done_reports: assert property (raw_mode_out && adc_done_in |=>
    conv_done_out && adc_output_out != 8'h00) else $error("conversion lost");
  a_upper_keys_idle: assert property (raw_mode_out |=>
    (press_flags_out[3:1] & ~$past(press_flags_out[3:1])) == 3'h0) else $error("key bin");
  a_int_follows_flags: assert property (int_n_out ==
    !(|press_flags_out || |release_flags_out || conv_done_out)) else $error("int level");
  a_disable_clears: assert property (!key_detection_enable_in |=>
    press_flags_out == 4'h0 && release_flags_out == 4'h0) else $error("flags kept");
  a_press_clears_rel: assert property ($rose(press_flags_out[0]) |->
    !release_flags_out[0]) else $error("release kept");
  a_release_quiet: assert property ($rose(release_flags_out[0]) |->
    !$past(key_low_in)) else $error("early release");
  a_start_single: assert property (adc_start_out |=> !adc_start_out)
    else $error("start held");
endmodule : key_raw_report_properties

/* File: dv/key_raw_report_tb.sv */
/* self-checking bench for key_raw_report with a converter model.
   assumes debounce counts shortened to 4 cycles. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module key_raw_report_tb;
  logic       clk = 1'b0, rst = 1'b1, en = 1'b0, raw = 1'b0, trig = 1'b0, rem = 1'b0;
  logic       fclr = 1'b0, key = 1'b0, start, done, rmode, cd, int_n;
  logic [3:0] lat = 4'h2, pf, rf;
  logic [7:0] val = 8'h00, code, adc;
  int         error_cnt = 0;
  int         n_tests = 0;
  always #4 clk = ~clk;
  key_raw_report #(.PRESS_DEB(4), .RELEASE_DEB(4)) i_dut (.ref_clk_in(clk), .rst_in(rst),
    .key_detection_enable_in(en), .raw_mode_en_in(raw), .manual_trigger_in(trig),
    .removal_in(rem), .flags_clear_in(fclr), .thr1_in(8'h40), .thr2_in(8'h80),
    .thr3_in(8'hc0), .key_low_in(key), .adc_start_out(start), .adc_done_in(done),
    .adc_code_in(code), .raw_mode_out(rmode), .adc_output_out(adc), .press_flags_out(pf),
    .release_flags_out(rf), .conv_done_out(cd), .int_n_out(int_n));
  adc_model i_adc (.clk_in(clk), .start_in(start), .lat_in(lat), .val_in(val),
    .done_out(done), .code_out(code));
  task automatic conclude();
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic wait_int();
    int i;
    for (i = 0; i < 60 && int_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 60) begin
      error_cnt++;
      conclude();
    end
  endtask : wait_int
  task automatic clear_flags();
    @(posedge clk) fclr <= 1'b1;
    @(posedge clk) fclr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : clear_flags
  task automatic convert(input logic [7:0] v, input logic [3:0] l);
    @(posedge clk) val <= v;
    lat <= l;
    trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    wait_int();
    `CHK("adc", (v == 8'h00) ? 8'h01 : v, adc)
    `CHK("press", 4'h0, pf)
    `CHK("done", 1'b1, cd)
    clear_flags();
    `CHK("adc kept", (v == 8'h00) ? 8'h01 : v, adc)
  endtask : convert
  task automatic keep_pending();
    // bias is taken as applied before enable
    @(posedge clk) en <= 1'b1;
    key <= 1'b1;
    wait_int();
    @(posedge clk) raw <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("pending", 1'b1, |pf)
    @(posedge clk) key <= 1'b0;
    repeat (8) @(posedge clk);
    clear_flags();
  endtask : keep_pending
  task automatic raw_press();
    // code above every threshold would bin to the top key
    @(posedge clk) val <= 8'hd0;
    lat <= 4'h6;
    key <= 1'b1;
    wait_int();
    `CHK("press", 4'h1, pf)
    `CHK("adc", 8'hd0, adc)
    `CHK("done", 1'b1, cd)
    clear_flags();
    `CHK("int_n", 1'b1, int_n)
    @(posedge clk) key <= 1'b0;
    wait_int();
    `CHK("release", 4'h1, rf)
    clear_flags();
  endtask : raw_press
  task automatic clear_paths();
    @(posedge clk) rem <= 1'b1;
    @(posedge clk) rem <= 1'b0;
    #1;
    `CHK("adc", 8'h00, adc)
    convert(8'h5b, 4'h1);
    @(posedge clk) raw <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("adc", 8'h00, adc)
    // a trigger outside raw mode must not reach the converter
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1;
      `CHK("start", 1'b0, start)
    end
    @(posedge clk) raw <= 1'b1;
    key <= 1'b1;
    wait_int();
    @(posedge clk) en <= 1'b0;
    key <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("flags", 8'h00, {pf, rf})
    `CHK("raw", 1'b0, rmode)
  endtask : clear_paths
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    keep_pending();
    raw_press();
    convert(8'h00, 4'h0);
    clear_paths();
    conclude();
  end
endmodule : key_raw_report_tb
bind key_raw_report key_raw_report_properties i_props (.*);
